// ---- rtl/tpwm_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module tpwm_timer
	import tpwm_pkg::*;
#(
	parameter int DW = TPWM_DW,
	parameter int PW = TPWM_PW
)(
	// clock and reset
	input  wire logic               CLK_SYS,
	input  wire logic               RESET_N,
	// register port
	input  wire logic [TPWM_AW-1:0] REG_ADDR,
	input  wire logic [DW-1:0]      REG_WDATA,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	output logic [DW-1:0]           REG_RDATA,
	// channel A pin
	input  wire logic               PIN_A_IN,
	output logic                    PIN_A_OUT,
	output logic                    PIN_A_OE,
	// channel B pin
	input  wire logic               PIN_B_IN,
	output logic                    PIN_B_OUT,
	output logic                    PIN_B_OE
);

	logic [7:0]    ctrl_a_ff;
	logic [4:0]    ctrl_b_ff;
	logic [DW-1:0] cnt_ff;
	logic [DW-1:0] buf_a_ff;
	logic [DW-1:0] buf_b_ff;
	logic [DW-1:0] capt_ff;
	logic [5:0]    flags_ff;
	logic [3:0]    port_ff;
	logic [PW-1:0] pre_ff;
	logic [DW-1:0] rdata_ff;
	tpwm_dir_t     dir_ff;
	logic [1:0]    s1_ff;
	logic [1:0]    s2_ff;
	logic [1:0]    s3_ff;
	logic [1:0]    pin_in_ff;

	logic [3:0]    wgm;
	logic [1:0]    beh_a;
	logic [1:0]    beh_b;
	logic [2:0]    csel;
	logic          active;
	logic          tick;
	logic          go;
	logic [DW-1:0] top;
	logic [DW-1:0] ocr_a;
	logic [DW-1:0] ocr_b;
	logic          oc_a;
	logic          oc_b;
	logic          match_a;
	logic          match_b;
	logic          conn_a;
	logic          conn_b;
	logic          slope_up;
	logic          at_bottom;
	logic          at_top;
	logic          load;
	logic          wr_cnt;
	logic [5:0]    flag_set;
	logic [5:0]    flag_clr;
	logic [DW-1:0] rd_val;

	// prescaler mask for a clock select code
	function automatic logic [PW-1:0] pre_mask(input logic [2:0] sel);
		case (sel)
			TPWM_CS_1:    pre_mask = TPWM_MASK_1;
			TPWM_CS_8:    pre_mask = TPWM_MASK_8;
			TPWM_CS_64:   pre_mask = TPWM_MASK_64;
			TPWM_CS_256:  pre_mask = TPWM_MASK_256;
			TPWM_CS_1024: pre_mask = TPWM_MASK_1024;
			default:      pre_mask = TPWM_MASK_1024;
		endcase
	endfunction

	// field decode; waveform select joined from both control registers
	assign wgm = {ctrl_b_ff[TPWM_WGM_HI_LSB +: 2], ctrl_a_ff[TPWM_WGM_LO_LSB +: 2]};
	assign beh_a = ctrl_a_ff[TPWM_BEH_A_LSB +: 2];
	assign beh_b = ctrl_a_ff[TPWM_BEH_B_LSB +: 2];
	assign csel = ctrl_b_ff[TPWM_CS_LSB +: 3];
	assign active = (wgm == TPWM_WGM_PFC_CAPT) || (wgm == TPWM_WGM_PFC_CMPA);
	assign top = (wgm == TPWM_WGM_PFC_CAPT) ? capt_ff : ocr_a;

	// prescaled tick acts as an enable on the one clock
	assign tick = (csel != TPWM_CS_STOP) && (csel <= TPWM_CS_1024)
		&& ((pre_ff & pre_mask(csel)) == pre_mask(csel));
	assign go = tick && active;
	assign wr_cnt = REG_WR && (REG_ADDR == TPWM_REG_COUNT);

	// turning points; the extremes decide the slope for matches
	assign at_bottom = (cnt_ff == TPWM_BOTTOM);
	assign at_top = (cnt_ff >= top) && !at_bottom;
	assign slope_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : (dir_ff == TPWM_UP));
	// buffers transparent outside the mode, else loaded at bottom
	assign load = !active || (go && at_bottom);

	// prescaler runs while a clock is selected
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			pre_ff <= '0;
		else if (csel == TPWM_CS_STOP)
			pre_ff <= '0;
		else
			pre_ff <= pre_ff + 1'b1;
	end

	// dual-slope counter
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cnt_ff <= TPWM_BOTTOM;
			dir_ff <= TPWM_UP;
		end
		else if (wr_cnt)
			cnt_ff <= REG_WDATA;
		else if (go)
		begin
			if (at_bottom)
			begin
				cnt_ff <= cnt_ff + TPWM_ONE;
				dir_ff <= TPWM_UP;
			end
			else if (at_top)
			begin
				cnt_ff <= cnt_ff - TPWM_ONE;
				dir_ff <= TPWM_DOWN;
			end
			else
			begin
				case (dir_ff)
					TPWM_UP:   cnt_ff <= cnt_ff + TPWM_ONE;
					TPWM_DOWN: cnt_ff <= cnt_ff - TPWM_ONE;
					default:   cnt_ff <= cnt_ff - TPWM_ONE;
				endcase
			end
		end
	end

	// compare channels
	tpwm_chan #(.DW(DW)) u_chan_a (
		.clk       (CLK_SYS),
		.reset_n   (RESET_N),
		.tick      (go),
		.cnt       (cnt_ff),
		.slope_up  (slope_up),
		.beh       (beh_a),
		.toggle_ok (active),
		.buf_val   (buf_a_ff),
		.load      (load),
		.ocr       (ocr_a),
		.oc        (oc_a),
		.match     (match_a),
		.connected (conn_a)
	);

	tpwm_chan #(.DW(DW)) u_chan_b (
		.clk       (CLK_SYS),
		.reset_n   (RESET_N),
		.tick      (go),
		.cnt       (cnt_ff),
		.slope_up  (slope_up),
		.beh       (beh_b),
		.toggle_ok (1'b0),
		.buf_val   (buf_b_ff),
		.load      (load),
		.ocr       (ocr_b),
		.oc        (oc_b),
		.match     (match_b),
		.connected (conn_b)
	);

	// flag events; a set wins over a clear in the same cycle
	always_comb
	begin
		flag_set = '0;
		flag_set[TPWM_FL_OVF] = go && at_bottom;
		flag_set[TPWM_FL_CMPA] = match_a;
		flag_set[TPWM_FL_CMPB] = match_b;
		flag_set[TPWM_FL_CAPT] = go && at_top && (wgm == TPWM_WGM_PFC_CAPT);
		flag_clr = (REG_WR && (REG_ADDR == TPWM_REG_FLAGS)) ? REG_WDATA[5:0] : 6'h00;
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			flags_ff <= '0;
		else
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
	end

	// configuration registers
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ctrl_a_ff <= '0;
			ctrl_b_ff <= '0;
			buf_a_ff <= TPWM_ZERO16;
			buf_b_ff <= TPWM_ZERO16;
			capt_ff <= TPWM_ZERO16;
			port_ff <= '0;
		end
		else if (REG_WR)
		begin
			case (REG_ADDR)
				TPWM_REG_CTRL_A:  ctrl_a_ff <= REG_WDATA[7:0];
				TPWM_REG_CTRL_B:  ctrl_b_ff <= REG_WDATA[4:0];
				TPWM_REG_CMP_A:   buf_a_ff <= REG_WDATA;
				TPWM_REG_CMP_B:   buf_b_ff <= REG_WDATA;
				TPWM_REG_CAPTURE: capt_ff <= REG_WDATA;
				TPWM_REG_PORT:    port_ff <= REG_WDATA[3:0];
				default:          port_ff <= port_ff;
			endcase
		end
	end

	// pin inputs: three stages, accepted once stages two and three agree
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			pin_in_ff <= '0;
		end
		else
		begin
			s1_ff <= {PIN_B_IN, PIN_A_IN};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff[0] == s3_ff[0])
				pin_in_ff[0] <= s3_ff[0];
			if (s2_ff[1] == s3_ff[1])
				pin_in_ff[1] <= s3_ff[1];
		end
	end

	// read mux
	always_comb
	begin
		rd_val = TPWM_ZERO16;
		case (REG_ADDR)
			TPWM_REG_CTRL_A:  rd_val[7:0] = ctrl_a_ff;
			TPWM_REG_CTRL_B:  rd_val[4:0] = ctrl_b_ff;
			TPWM_REG_COUNT:   rd_val = cnt_ff;
			TPWM_REG_CMP_A:   rd_val = buf_a_ff;
			TPWM_REG_CMP_B:   rd_val = buf_b_ff;
			TPWM_REG_CAPTURE: rd_val = capt_ff;
			TPWM_REG_FLAGS:   rd_val[5:0] = flags_ff;
			TPWM_REG_PORT:    rd_val[5:0] = {pin_in_ff, port_ff};
			default:          rd_val = TPWM_ZERO16;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
			rdata_ff <= TPWM_ZERO16;
		else
			rdata_ff <= REG_RD ? rd_val : TPWM_ZERO16;
	end
	assign REG_RDATA = rdata_ff;

	// pin muxing: waveform when connected, else port data
	assign PIN_A_OUT = conn_a ? oc_a : port_ff[TPWM_PT_DAT_A];
	assign PIN_B_OUT = conn_b ? oc_b : port_ff[TPWM_PT_DAT_B];
	assign PIN_A_OE = port_ff[TPWM_PT_DIR_A];
	assign PIN_B_OE = port_ff[TPWM_PT_DIR_B];

	// checks
	a_mode_select: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(!active && !wr_cnt) |=> $stable(cnt_ff))
		else $error("counter moved outside the dual-slope mode");

	a_bottom_turn: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(go && at_bottom && !wr_cnt) |=> (cnt_ff == TPWM_ONE) && (dir_ff == TPWM_UP))
		else $error("counter did not turn up at bottom");

	a_top_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(go && at_top && !wr_cnt && cnt_ff == top) |=> (cnt_ff == $past(cnt_ff) - TPWM_ONE))
		else $error("counter did not leave top after one tick");

	a_tick_enable: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(!tick && !wr_cnt) |=> ($stable(cnt_ff) && $stable(ocr_a)) || !$past(active))
		else $error("counter moved without a tick");

	a_ovf_load: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(go && at_bottom) |=> flags_ff[TPWM_FL_OVF] && (ocr_b == $past(buf_b_ff)))
		else $error("bottom did not load buffer and set overflow");

	a_capt_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(go && at_top && wgm == TPWM_WGM_PFC_CAPT) |=> flags_ff[TPWM_FL_CAPT])
		else $error("capture flag missing at top");

	a_flag_set_wins: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(match_b && flag_clr[TPWM_FL_CMPB]) |=> flags_ff[TPWM_FL_CMPB])
		else $error("compare flag lost to a clear");

	a_ninv_level: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(match_b && beh_b == TPWM_BEH_NINV) |=> (oc_b == !$past(slope_up)))
		else $error("non-inverted level wrong after match");

	a_pin_drive: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(match_a && conn_a && PIN_A_OE && !REG_WR && beh_a == TPWM_BEH_NINV) |=> (PIN_A_OUT == !$past(slope_up)))
		else $error("pin does not show the waveform");

	c_full_period: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(go && at_top) ##[1:1000] (go && at_bottom));
	c_toggle_a: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(match_a && beh_a == TPWM_BEH_TOGGLE));
	c_inv_b: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		(match_b && beh_b == TPWM_BEH_INV && !slope_up));

endmodule
`default_nettype wire

// ---- rtl/tpwm_pkg.sv ----
`default_nettype none
package tpwm_pkg;

	// data and address widths of the register port, and prescaler width
	localparam int TPWM_DW = 16;
	localparam int TPWM_AW = 3;
	localparam int TPWM_PW = 10;

	// register indices
	localparam logic [2:0] TPWM_REG_CTRL_A  = 3'h0;
	localparam logic [2:0] TPWM_REG_CTRL_B  = 3'h1;
	localparam logic [2:0] TPWM_REG_COUNT   = 3'h2;
	localparam logic [2:0] TPWM_REG_CMP_A   = 3'h3;
	localparam logic [2:0] TPWM_REG_CMP_B   = 3'h4;
	localparam logic [2:0] TPWM_REG_CAPTURE = 3'h5;
	localparam logic [2:0] TPWM_REG_FLAGS   = 3'h6;
	localparam logic [2:0] TPWM_REG_PORT    = 3'h7;

	// control register A fields
	localparam int TPWM_BEH_A_LSB = 6;
	localparam int TPWM_BEH_B_LSB = 4;
	localparam int TPWM_WGM_LO_LSB = 0;
	// control register B fields
	localparam int TPWM_WGM_HI_LSB = 3;
	localparam int TPWM_CS_LSB = 0;
	// flag register bit positions
	localparam int TPWM_FL_OVF  = 0;
	localparam int TPWM_FL_CMPA = 1;
	localparam int TPWM_FL_CMPB = 2;
	localparam int TPWM_FL_CAPT = 5;
	// port register bit positions
	localparam int TPWM_PT_DIR_A = 0;
	localparam int TPWM_PT_DIR_B = 1;
	localparam int TPWM_PT_DAT_A = 2;
	localparam int TPWM_PT_DAT_B = 3;
	localparam int TPWM_PT_IN_A  = 4;
	localparam int TPWM_PT_IN_B  = 5;

	// waveform select values of the dual-slope frequency correct modes
	localparam logic [3:0] TPWM_WGM_PFC_CAPT = 4'h8;
	localparam logic [3:0] TPWM_WGM_PFC_CMPA = 4'h9;

	// output behaviour field codes
	localparam logic [1:0] TPWM_BEH_OFF    = 2'h0;
	localparam logic [1:0] TPWM_BEH_TOGGLE = 2'h1;
	localparam logic [1:0] TPWM_BEH_NINV   = 2'h2;
	localparam logic [1:0] TPWM_BEH_INV    = 2'h3;

	// clock select codes and prescaler masks
	localparam logic [2:0] TPWM_CS_STOP = 3'h0;
	localparam logic [2:0] TPWM_CS_1    = 3'h1;
	localparam logic [2:0] TPWM_CS_8    = 3'h2;
	localparam logic [2:0] TPWM_CS_64   = 3'h3;
	localparam logic [2:0] TPWM_CS_256  = 3'h4;
	localparam logic [2:0] TPWM_CS_1024 = 3'h5;
	localparam logic [9:0] TPWM_MASK_1    = 10'h000;
	localparam logic [9:0] TPWM_MASK_8    = 10'h007;
	localparam logic [9:0] TPWM_MASK_64   = 10'h03F;
	localparam logic [9:0] TPWM_MASK_256  = 10'h0FF;
	localparam logic [9:0] TPWM_MASK_1024 = 10'h3FF;

	localparam logic [15:0] TPWM_BOTTOM = 16'h0000;
	localparam logic [15:0] TPWM_ONE    = 16'h0001;
	localparam logic [15:0] TPWM_ZERO16 = 16'h0000;

	// counting direction, one-hot
	typedef enum logic [1:0] {
		TPWM_UP   = 2'b01,
		TPWM_DOWN = 2'b10
	} tpwm_dir_t;

endpackage
`default_nettype wire

// ---- rtl/tpwm_chan.sv ----
`timescale 1ns/100ps
`default_nettype none
module tpwm_chan
	import tpwm_pkg::*;
#(
	parameter int DW = TPWM_DW
)(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// counter state
	input  wire logic          tick,
	input  wire logic [DW-1:0] cnt,
	input  wire logic          slope_up,
	// configuration
	input  wire logic [1:0]    beh,
	input  wire logic          toggle_ok,
	input  wire logic [DW-1:0] buf_val,
	input  wire logic          load,
	// results
	output logic [DW-1:0]      ocr,
	output logic               oc,
	output logic               match,
	output logic               connected
);

	logic [DW-1:0] ocr_ff;
	logic          oc_ff;

	// match only on an enabled tick
	assign match = tick && (cnt == ocr_ff);
	assign ocr = ocr_ff;
	assign oc = oc_ff;
	// disconnected on 00, and on 01 unless toggling is allowed
	assign connected = (beh == TPWM_BEH_NINV) || (beh == TPWM_BEH_INV)
		|| ((beh == TPWM_BEH_TOGGLE) && toggle_ok);

	// active compare value, reloaded from the buffer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ocr_ff <= TPWM_ZERO16;
		else if (load)
			ocr_ff <= buf_val;
	end

	// waveform latch: clear/set by slope, or toggle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			oc_ff <= 1'b0;
		else if (match)
		begin
			case (beh)
				TPWM_BEH_NINV:   oc_ff <= !slope_up;
				TPWM_BEH_INV:    oc_ff <= slope_up;
				TPWM_BEH_TOGGLE: oc_ff <= toggle_ok ? !oc_ff : oc_ff;
				default:         oc_ff <= oc_ff;
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- verif/tpwm_load.sv ----
`timescale 1ns/100ps
`default_nettype none
module tpwm_load
(
	// pin drive from the timer
	input  wire logic out_a,
	input  wire logic oe_a,
	input  wire logic out_b,
	input  wire logic oe_b,
	// levels seen on the board
	output logic      in_a,
	output logic      in_b
);
	// motor driver inputs carry a pull-up, so an undriven pin floats high
	assign in_a = oe_a ? out_a : 1'b1;
	assign in_b = oe_b ? out_b : 1'b1;
endmodule
`default_nettype wire

// ---- verif/tpwm_timer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module tpwm_timer_test
	import tpwm_pkg::*;
();
	logic        clk_sys   = 1'b0;
	logic        reset_n   = 1'b0;
	logic [2:0]  reg_addr  = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [15:0] reg_rdata;
	logic        pin_a_in;
	logic        pin_b_in;
	logic        pin_a_out;
	logic        pin_b_out;
	logic        pin_a_oe;
	logic        pin_b_oe;
	integer      n_errors  = 0;
	integer      cmp_count = 0;
	integer      seed      = 33652;
	integer      cyc       = 0;

	// 125 MHz system clock
	always #4 clk_sys = ~clk_sys;

	tpwm_timer dut_u (
		.CLK_SYS   (clk_sys),
		.RESET_N   (reset_n),
		.REG_ADDR  (reg_addr),
		.REG_WDATA (reg_wdata),
		.REG_WR    (reg_wr),
		.REG_RD    (reg_rd),
		.REG_RDATA (reg_rdata),
		.PIN_A_IN  (pin_a_in),
		.PIN_A_OUT (pin_a_out),
		.PIN_A_OE  (pin_a_oe),
		.PIN_B_IN  (pin_b_in),
		.PIN_B_OUT (pin_b_out),
		.PIN_B_OE  (pin_b_oe)
	);

	tpwm_load load_u (
		.out_a (pin_a_out),
		.oe_a  (pin_a_oe),
		.out_b (pin_b_out),
		.oe_b  (pin_b_oe),
		.in_a  (pin_a_in),
		.in_b  (pin_b_in)
	);

	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard, well above the roughly 42000 cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			n_errors = n_errors + 1;
			$display("[ERR] timeout expected 0 seen 1");
			finish_test;
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkp(input string nm, input logic e, input logic g);
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// high cycles of both pins over a window
	task automatic meas(input int n, output logic [15:0] ha, output logic [15:0] hb);
		ha = 16'h0000;
		hb = 16'h0000;
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			ha = ha + {15'h0000, pin_a_in};
			hb = hb + {15'h0000, pin_b_in};
		end
	endtask

	// high time of one dual-slope period: non-inverted is low from up-match to down-match, inverted is high
	function automatic logic [15:0] hi(input logic [15:0] t, input logic [15:0] c, input logic inv);
		hi = inv ? 16'(2 * (t - c)) : 16'(2 * c);
	endfunction

	// clock cycles per timer tick for a clock select code
	function automatic int pre_div(input logic [2:0] cs);
		case (cs)
			TPWM_CS_8:    pre_div = 16'h0008;
			TPWM_CS_64:   pre_div = 16'h0040;
			TPWM_CS_256:  pre_div = 16'h0100;
			TPWM_CS_1024: pre_div = 16'h0400;
			default:      pre_div = 16'h0001;
		endcase
	endfunction

	// stop, program, start at count zero, let buffers load at bottom
	task automatic setup(input logic [3:0] wgm, input logic [1:0] ba, input logic [1:0] bb,
		input logic [15:0] top, input logic [15:0] ca, input logic [15:0] cb);
		wr(TPWM_REG_CTRL_B, 16'h0000);
		wr(TPWM_REG_COUNT, 16'h0000);
		wr(TPWM_REG_CAPTURE, top);
		wr(TPWM_REG_CMP_A, ca);
		wr(TPWM_REG_CMP_B, cb);
		wr(TPWM_REG_PORT, 16'h0003);
		wr(TPWM_REG_CTRL_A, {8'h00, ba, bb, 2'h0, wgm[1:0]});
		wr(TPWM_REG_CTRL_B, {11'h000, wgm[3:2], TPWM_CS_1});
		idle(4 * top + 8);
	endtask

	// clear flags, wait one full period, read them back
	task automatic flags(input logic [15:0] top, input logic [15:0] msk, input logic [15:0] e);
		logic [15:0] d;
		wr(TPWM_REG_FLAGS, 16'h00FF);
		idle(2 * top + 4);
		rd(TPWM_REG_FLAGS, d);
		chk("flags", e, d & msk);
	endtask

	initial
	begin
		logic [15:0] top;
		logic [15:0] ca;
		logic [15:0] cb;
		logic [15:0] ha;
		logic [15:0] hb;
		logic [15:0] d;
		logic [1:0]  bm;
		integer      k;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		chkp("oe_a", 1'b0, pin_a_oe);
		rd(TPWM_REG_FLAGS, d);
		chk("flags_rst", 16'h0000, d);
		endt("reset");
		// random periods, duty corners first
		for (k = 0; k < 8; k++)
		begin
			top = 16'h0003 + 16'($unsigned($random(seed)) % 14);
			ca = 16'($unsigned($random(seed)) % (top + 1));
			cb = 16'($unsigned($random(seed)) % (top + 1));
			if (k < 4)
				cb = k[0] ? top : 16'h0000;
			bm = k[1] ? TPWM_BEH_INV : TPWM_BEH_NINV;
			if (!k[2])
			begin
				setup(TPWM_WGM_PFC_CAPT, bm, bm, top, ca, cb);
				meas(2 * top, ha, hb);
				chk("high_a", hi(top, ca, k[1]), ha);
				chk("high_b", hi(top, cb, k[1]), hb);
				flags(top, 16'h003F, 16'h0027);
			end
			else
			begin
				setup(TPWM_WGM_PFC_CMPA, TPWM_BEH_TOGGLE, bm, top, top, cb);
				meas(4 * top, ha, hb);
				chk("high_a", 16'(2 * top), ha);
				chk("high_b", 16'(2 * hi(top, cb, k[1])), hb);
				flags(top, 16'h001F, 16'h0007);
			end
			rd(TPWM_REG_COUNT, d);
			chk("count_range", 16'h0001, {15'h0000, d <= top});
			endt("pwm");
		end
		// compare above top never matches
		setup(TPWM_WGM_PFC_CAPT, TPWM_BEH_NINV, TPWM_BEH_NINV, 16'h0005, 16'h0002, 16'h0006);
		flags(16'h0005, 16'h0004, 16'h0000);
		endt("no_match");
		// prescalers 8 to 1024: channel A high four ticks of a ten tick period
		for (k = 2; k < 6; k++)
		begin
			wr(TPWM_REG_CTRL_B, {11'h000, 2'h2, 3'(k)});
			idle(20 * pre_div(3'(k)));
			meas(10 * pre_div(3'(k)), ha, hb);
			chk("high_a_pre", 16'(4 * pre_div(3'(k))), ha);
		end
		endt("prescale");
		// no tick, no count
		wr(TPWM_REG_CTRL_B, {11'h000, 2'h2, TPWM_CS_STOP});
		wr(TPWM_REG_COUNT, 16'h0002);
		idle(20);
		rd(TPWM_REG_COUNT, d);
		chk("count_stop", 16'h0002, d);
		// other mode holds the counter
		wr(TPWM_REG_CTRL_B, {11'h000, 2'h0, TPWM_CS_1});
		idle(20);
		rd(TPWM_REG_COUNT, d);
		chk("count_mode0", 16'h0002, d);
		endt("freeze");
		// A disconnected and input only, B toggle code falls back to port
		setup(TPWM_WGM_PFC_CAPT, TPWM_BEH_OFF, TPWM_BEH_TOGGLE, 16'h0004, 16'h0001, 16'h0001);
		wr(TPWM_REG_PORT, 16'h000E);
		idle(5);
		chkp("oe_a", 1'b0, pin_a_oe);
		chkp("out_a", 1'b1, pin_a_out);
		chkp("oe_b", 1'b1, pin_b_oe);
		chkp("out_b", 1'b1, pin_b_out);
		rd(TPWM_REG_PORT, d);
		chk("port", 16'h003E, d);
		wr(TPWM_REG_PORT, 16'h0006);
		meas(8, ha, hb);
		chk("high_b_port", 16'h0000, hb);
		chk("high_a_port", 16'h0008, ha);
		rd(TPWM_REG_PORT, d);
		chk("port", 16'h0016, d);
		endt("port");
		finish_test;
	end
endmodule
`default_nettype wire
